// ===== rtl/alu_core.sv
// arithmetic and logic datapath with register file, io bit space and apb slave
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module alu_core (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // peripheral flag events
  input wire logic IO_FLAG_STB,
  input wire logic [4:0] IO_FLAG_ADDR,
  input wire logic [7:0] IO_FLAG_SET,
  // status
  output logic BUSY,
  output logic SKIP
);

  logic [7:0] gpr [32];
  logic [7:0] io [32];
  logic [7:0] next_io [32];
  alu_pkg::alu_state_t state;
  alu_pkg::alu_state_t next_state;
  logic [5:0] flags;
  logic [5:0] next_flags;
  logic [4:0] op;
  logic [4:0] dst;
  logic [4:0] src;
  logic [5:0] io_addr;
  logic [7:0] imm;
  logic [2:0] bit_sel;
  logic [7:0] hold_high;
  logic [4:0] gpr_sel;
  logic [4:0] io_sel;
  logic skip;
  logic next_skip;

  // apb decode
  wire access = PSEL && PENABLE && CE;
  wire wr = access && PWRITE;
  wire hit_cmd = PADDR == alu_pkg::ALU_CMD_OFFSET;
  wire hit_status = PADDR == alu_pkg::ALU_STATUS_OFFSET;
  wire hit_gsel = PADDR == alu_pkg::ALU_GPR_SEL_OFFSET;
  wire hit_gdata = PADDR == alu_pkg::ALU_GPR_DATA_OFFSET;
  wire hit_isel = PADDR == alu_pkg::ALU_IO_SEL_OFFSET;
  wire hit_idata = PADDR == alu_pkg::ALU_IO_DATA_OFFSET;
  wire mapped = hit_cmd | hit_status | hit_gsel | hit_gdata | hit_isel | hit_idata;
  wire idle = state == alu_pkg::ALU_IDLE;
  // commands and data writes arriving while busy are dropped
  wire start = wr && hit_cmd && idle;
  wire bus_gpr_wr = wr && hit_gdata && idle;
  wire bus_io_wr = wr && hit_idata && idle;
  wire bus_flag_wr = wr && hit_status && idle;

  assign PREADY = CE;
  assign PSLVERR = access && !mapped;
  assign BUSY = !idle;
  assign SKIP = skip;

  wire [31:0] status_word = {22'h0, skip, !idle, 2'b00, flags};
  assign PRDATA = !(PSEL && PENABLE && !PWRITE) ? 32'h0000_0000 :
                  hit_status ? status_word :
                  hit_gsel ? {27'h0, gpr_sel} :
                  hit_gdata ? {24'h0, gpr[gpr_sel]} :
                  hit_isel ? {27'h0, io_sel} :
                  hit_idata ? {24'h0, io[io_sel]} :
                  hit_cmd ? {5'h0, bit_sel, imm, io_addr[5], src, dst, op} : 32'h0000_0000;

  // 8-bit add or subtract with carry in; returns {h, v, c, result}
  function automatic logic [10:0] arith8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin, input logic sub);
    logic [7:0] r;
    logic h;
    logic c;
    logic v;
    r = sub ? 8'(a - b - {7'h0, cin}) : 8'(a + b + {7'h0, cin});
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
    arith8 = {h, v, c, r};
  endfunction

  // operand fetch
  wire [7:0] rd = gpr[dst];
  wire [7:0] rr = gpr[src];
  wire [4:0] dst_high = 5'(dst + 5'h01);
  wire [15:0] word_in = {gpr[dst_high], rd};
  wire [15:0] word_k = {10'h000, imm[5:0]};
  wire word_sub = op == alu_pkg::ALU_OP_WORD_IMMEDIATE_DIFFERENCE;
  wire [15:0] word_res = word_sub ? 16'(word_in - word_k) : 16'(word_in + word_k);
  wire io_in_range = io_addr <= alu_pkg::ALU_IO_BIT_LAST;
  wire [7:0] io_cur = io[io_addr[4:0]];
  wire io_bit = io_cur[bit_sel];
  wire [7:0] bit_onehot = 8'h01 << bit_sel;
  wire carry = flags[alu_pkg::ALU_FLAG_C];

  // shared adder inputs
  logic [7:0] ar_a;
  logic [7:0] ar_b;
  logic ar_cin;
  logic ar_sub;
  always_comb begin
    ar_a = rd;
    ar_b = rr;
    ar_cin = 1'b0;
    ar_sub = 1'b0;
    unique case (op)
      alu_pkg::ALU_OP_ADD_CARRY: ar_cin = carry;
      alu_pkg::ALU_OP_SUB: ar_sub = 1'b1;
      alu_pkg::ALU_OP_DIFFERENCE_WITH_CARRY: begin
        ar_sub = 1'b1;
        ar_cin = carry;
      end
      alu_pkg::ALU_OP_DIFFERENCE_IMMEDIATE: begin
        ar_sub = 1'b1;
        ar_b = imm;
      end
      alu_pkg::ALU_OP_DIFFERENCE_CARRY_IMMEDIATE: begin
        ar_sub = 1'b1;
        ar_b = imm;
        ar_cin = carry;
      end
      alu_pkg::ALU_OP_TWOS_INVERT: begin
        ar_sub = 1'b1;
        ar_a = 8'h00;
        ar_b = rd;
      end
      alu_pkg::ALU_OP_PLUS_ONE: ar_b = 8'h01;
      alu_pkg::ALU_OP_MINUS_ONE: begin
        ar_sub = 1'b1;
        ar_b = 8'h01;
      end
      default: ;
    endcase
  end
  wire [10:0] ar = arith8(ar_a, ar_b, ar_cin, ar_sub);
  wire [7:0] ar_res = ar[7:0];

  // word flags from the held result and the original high byte
  logic [15:0] word_res_q;
  logic word_high_in;
  wire word_v = word_sub ? (word_high_in & ~word_res_q[15]) : (~word_high_in & word_res_q[15]);
  wire word_c = word_sub ? (word_res_q[15] & ~word_high_in) : (~word_res_q[15] & word_high_in);

  // datapath result and flag update
  logic [7:0] res;
  logic res_wr;
  logic [4:0] res_addr;
  logic io_op_wr;
  logic [7:0] io_op_val;
  logic [7:0] io_op_clr;
  always_comb begin
    next_state = state;
    next_flags = flags; // [RULE_19]
    next_skip = skip;
    res = ar_res;
    res_wr = 1'b0;
    res_addr = dst;
    io_op_wr = 1'b0;
    io_op_val = io_cur;
    io_op_clr = 8'h00;
    unique case (state)
      alu_pkg::ALU_IDLE: begin
        if (start) begin
          next_state = alu_pkg::ALU_EXEC;
        end
      end
      alu_pkg::ALU_EXEC: begin
        next_state = alu_pkg::ALU_IDLE;
        unique case (op)
          alu_pkg::ALU_OP_ADD, alu_pkg::ALU_OP_ADD_CARRY, alu_pkg::ALU_OP_SUB,
          alu_pkg::ALU_OP_DIFFERENCE_WITH_CARRY, alu_pkg::ALU_OP_DIFFERENCE_IMMEDIATE,
          alu_pkg::ALU_OP_DIFFERENCE_CARRY_IMMEDIATE, alu_pkg::ALU_OP_TWOS_INVERT: begin
            // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_12]
            res_wr = 1'b1;
            next_flags[alu_pkg::ALU_FLAG_H] = ar[10];
            next_flags[alu_pkg::ALU_FLAG_V] = ar[9];
            next_flags[alu_pkg::ALU_FLAG_C] = ar[8];
          end
          alu_pkg::ALU_OP_PLUS_ONE, alu_pkg::ALU_OP_MINUS_ONE: begin
            res_wr = 1'b1; // [RULE_12]
            next_flags[alu_pkg::ALU_FLAG_V] = ar[9];
          end
          alu_pkg::ALU_OP_ONES_INVERT: begin
            res = 8'(alu_pkg::ALU_ALL_ONES - rd); // [RULE_12]
            res_wr = 1'b1;
            next_flags[alu_pkg::ALU_FLAG_C] = 1'b1;
            next_flags[alu_pkg::ALU_FLAG_V] = 1'b0;
          end
          alu_pkg::ALU_OP_AND, alu_pkg::ALU_OP_MASK_AND_IMMEDIATE, alu_pkg::ALU_OP_OR,
          alu_pkg::ALU_OP_OR_IMMEDIATE, alu_pkg::ALU_OP_EXCLUSIVE_OR_REGISTERS,
          alu_pkg::ALU_OP_SET_BITS_MASK, alu_pkg::ALU_OP_CLEAR_BITS_MASK,
          alu_pkg::ALU_OP_ZERO_SIGN_TEST: begin
            unique case (op)
              alu_pkg::ALU_OP_AND: res = rd & rr; // [RULE_07]
              alu_pkg::ALU_OP_MASK_AND_IMMEDIATE: res = rd & imm; // [RULE_07]
              alu_pkg::ALU_OP_OR: res = rd | rr; // [RULE_08]
              alu_pkg::ALU_OP_EXCLUSIVE_OR_REGISTERS: res = rd ^ rr; // [RULE_08]
              alu_pkg::ALU_OP_CLEAR_BITS_MASK: res = rd & 8'(alu_pkg::ALU_ALL_ONES - imm); // [RULE_10]
              alu_pkg::ALU_OP_ZERO_SIGN_TEST: res = rd & rd; // [RULE_11]
              default: res = rd | imm; // [RULE_08] [RULE_09]
            endcase
            res_wr = 1'b1;
            next_flags[alu_pkg::ALU_FLAG_V] = 1'b0;
          end
          alu_pkg::ALU_OP_WORD_IMMEDIATE_SUM, alu_pkg::ALU_OP_WORD_IMMEDIATE_DIFFERENCE: begin
            // low byte now, high byte and flags on the second clock [RULE_05] [RULE_06]
            res = word_res[7:0];
            res_wr = 1'b1;
            next_state = alu_pkg::ALU_EXEC2;
          end
          alu_pkg::ALU_OP_IO_BIT_SET, alu_pkg::ALU_OP_IO_BIT_CLEAR: begin
            next_state = alu_pkg::ALU_EXEC2;
          end
          alu_pkg::ALU_OP_SKIP_IF_IO_BIT_ONE: next_skip = io_in_range && io_bit; // [RULE_14]
          alu_pkg::ALU_OP_SKIP_IF_IO_BIT_ZERO: next_skip = io_in_range && !io_bit; // [RULE_14]
          default: ;
        endcase
        if (res_wr) begin
          next_flags[alu_pkg::ALU_FLAG_Z] = res == 8'h00;
          next_flags[alu_pkg::ALU_FLAG_N] = res[7];
        end
      end
      alu_pkg::ALU_EXEC2: begin
        next_state = alu_pkg::ALU_IDLE;
        if (op == alu_pkg::ALU_OP_IO_BIT_SET || op == alu_pkg::ALU_OP_IO_BIT_CLEAR) begin
          // single bit only, so other clear-on-one flags stay intact [RULE_16]
          io_op_wr = io_in_range; // [RULE_13]
          if (op == alu_pkg::ALU_OP_IO_BIT_SET) begin
            io_op_val = io_cur | bit_onehot;
            io_op_clr = bit_onehot;
          end else begin
            io_op_val = io_cur & ~bit_onehot;
          end
        end else begin
          res = hold_high; // [RULE_05] [RULE_06]
          res_addr = dst_high;
          res_wr = 1'b1;
          next_flags[alu_pkg::ALU_FLAG_Z] = word_res_q == 16'h0000;
          next_flags[alu_pkg::ALU_FLAG_N] = word_res_q[15];
          next_flags[alu_pkg::ALU_FLAG_C] = word_c;
          next_flags[alu_pkg::ALU_FLAG_V] = word_v;
          next_flags[alu_pkg::ALU_FLAG_S] = word_res_q[15] ^ word_v;
        end
      end
    endcase
  end

  // io write merge: clear-on-one bits only clear, hardware set wins [RULE_15]
  wire io_wr = bus_io_wr | io_op_wr;
  wire [4:0] io_wr_addr = bus_io_wr ? io_sel : io_addr[4:0];
  wire [7:0] io_wr_val = bus_io_wr ? PWDATA[7:0] : io_op_val;
  wire [7:0] io_wr_clr = bus_io_wr ? PWDATA[7:0] : io_op_clr;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      next_io[i] = io[i];
      if (io_wr && io_wr_addr == 5'(i)) begin
        next_io[i] = (io_wr_val & ~alu_pkg::alu_w1c_mask(5'(i))) |
                     (io[i] & alu_pkg::alu_w1c_mask(5'(i)) & ~io_wr_clr); // [RULE_15]
      end
      if (IO_FLAG_STB && IO_FLAG_ADDR == 5'(i)) begin
        next_io[i] = next_io[i] | IO_FLAG_SET;
      end
    end
  end

  // control state
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= alu_pkg::ALU_IDLE;
      flags <= alu_pkg::ALU_FLAGS_RESET;
      skip <= 1'b0;
      op <= 5'h00;
      dst <= 5'h00;
      src <= 5'h00;
      io_addr <= 6'h00;
      imm <= alu_pkg::ALU_BYTE_RESET;
      bit_sel <= 3'h0;
      gpr_sel <= 5'h00;
      io_sel <= 5'h00;
    end else if (CE) begin
      state <= next_state;
      flags <= bus_flag_wr ? PWDATA[5:0] : next_flags;
      skip <= next_skip;
      if (start) begin
        op <= PWDATA[alu_pkg::ALU_CMD_OP_POS +: 5];
        dst <= PWDATA[alu_pkg::ALU_CMD_DST_POS +: 5];
        src <= PWDATA[alu_pkg::ALU_CMD_SRC_POS +: 5];
        io_addr <= PWDATA[alu_pkg::ALU_CMD_SRC_POS +: 6];
        imm <= PWDATA[alu_pkg::ALU_CMD_IMM_POS +: 8];
        bit_sel <= PWDATA[alu_pkg::ALU_CMD_BIT_POS +: 3];
      end
      if (wr && hit_gsel) begin
        gpr_sel <= PWDATA[4:0];
      end
      if (wr && hit_isel) begin
        io_sel <= PWDATA[4:0];
      end
    end
  end

  // word result hold between the two clocks
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hold_high <= alu_pkg::ALU_BYTE_RESET;
      word_res_q <= 16'h0000;
      word_high_in <= 1'b0;
    end else if (CE && state == alu_pkg::ALU_EXEC) begin
      hold_high <= word_res[15:8];
      word_res_q <= word_res;
      word_high_in <= word_in[15];
    end
  end

  // register file and io space; result lands at the end of the last clock, a word low byte at the end of the first [RULE_19]
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= alu_pkg::ALU_BYTE_RESET;
        io[i] <= alu_pkg::ALU_BYTE_RESET;
      end
    end else if (CE) begin
      if (res_wr) begin
        gpr[res_addr] <= res;
      end else if (bus_gpr_wr) begin
        gpr[gpr_sel] <= PWDATA[7:0];
      end
      for (int i = 0; i < 32; i++) begin
        io[i] <= next_io[i];
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/alu_pkg.sv
// package for the arithmetic and logic datapath: offsets, fields, opcodes
// Contract
// RULE_01: register add, with carry, flags ZCNVH, one clock
// RULE_02: register subtract, with carry, flags ZCNVH, one clock
// RULE_03: subtract immediate, flags ZCNVH, one clock
// RULE_04: subtract immediate and carry, flags ZCNVH, one clock
// RULE_05: word add immediate, flags ZCNVS, two clocks
// RULE_06: word subtract immediate, flags ZCNVS, two clocks
// RULE_07: AND register or constant, flags ZNV, one clock
// RULE_08: OR, OR immediate, XOR, flags ZNV, one clock
// RULE_09: set bits ORs mask, flags ZNV, one clock
// RULE_10: clear bits ANDs 0xFF minus mask, ZNV
// RULE_11: test ANDs register with itself, sets ZNV
// RULE_12: invert, negate, increment, decrement, one clock each
// RULE_13: bit set/clear only on I/O 0x00-0x1F
// RULE_14: skip tests one I/O bit, reports skip
// RULE_15: some flags clear on writing one
// RULE_16: bit set/clear touches only the addressed bit
// RULE_17: software writes zero to reserved bits
// RULE_18: software never writes reserved I/O addresses
// RULE_19: unlisted flags kept, result written at end; word ops write the low byte at the end of the first clock
package alu_pkg;
  // apb register byte offsets
  localparam logic [7:0] ALU_CMD_OFFSET = 8'h00;
  localparam logic [7:0] ALU_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] ALU_GPR_SEL_OFFSET = 8'h08;
  localparam logic [7:0] ALU_GPR_DATA_OFFSET = 8'h0c;
  localparam logic [7:0] ALU_IO_SEL_OFFSET = 8'h10;
  localparam logic [7:0] ALU_IO_DATA_OFFSET = 8'h14;
  // command word fields (lsb positions)
  localparam int ALU_CMD_OP_POS = 0;
  localparam int ALU_CMD_DST_POS = 5;
  localparam int ALU_CMD_SRC_POS = 10;
  localparam int ALU_CMD_IMM_POS = 16;
  localparam int ALU_CMD_BIT_POS = 24;
  // status word bit positions
  localparam int ALU_FLAG_C = 0;
  localparam int ALU_FLAG_Z = 1;
  localparam int ALU_FLAG_N = 2;
  localparam int ALU_FLAG_V = 3;
  localparam int ALU_FLAG_S = 4;
  localparam int ALU_FLAG_H = 5;
  localparam int ALU_STAT_BUSY = 8;
  localparam int ALU_STAT_SKIP = 9;
  // reset values
  localparam logic [5:0] ALU_FLAGS_RESET = 6'h00;
  localparam logic [7:0] ALU_BYTE_RESET = 8'h00;
  // bit-addressable io range ends here
  localparam logic [5:0] ALU_IO_BIT_LAST = 6'h1f;
  localparam logic [7:0] ALU_ALL_ONES = 8'hff;
  // opcodes
  localparam logic [4:0] ALU_OP_ADD = 5'h00;
  localparam logic [4:0] ALU_OP_ADD_CARRY = 5'h01;
  localparam logic [4:0] ALU_OP_SUB = 5'h02;
  localparam logic [4:0] ALU_OP_DIFFERENCE_WITH_CARRY = 5'h03;
  localparam logic [4:0] ALU_OP_DIFFERENCE_IMMEDIATE = 5'h04;
  localparam logic [4:0] ALU_OP_DIFFERENCE_CARRY_IMMEDIATE = 5'h05;
  localparam logic [4:0] ALU_OP_WORD_IMMEDIATE_SUM = 5'h06;
  localparam logic [4:0] ALU_OP_WORD_IMMEDIATE_DIFFERENCE = 5'h07;
  localparam logic [4:0] ALU_OP_AND = 5'h08;
  localparam logic [4:0] ALU_OP_MASK_AND_IMMEDIATE = 5'h09;
  localparam logic [4:0] ALU_OP_OR = 5'h0a;
  localparam logic [4:0] ALU_OP_OR_IMMEDIATE = 5'h0b;
  localparam logic [4:0] ALU_OP_EXCLUSIVE_OR_REGISTERS = 5'h0c;
  localparam logic [4:0] ALU_OP_ONES_INVERT = 5'h0d;
  localparam logic [4:0] ALU_OP_TWOS_INVERT = 5'h0e;
  localparam logic [4:0] ALU_OP_SET_BITS_MASK = 5'h0f;
  localparam logic [4:0] ALU_OP_CLEAR_BITS_MASK = 5'h10;
  localparam logic [4:0] ALU_OP_PLUS_ONE = 5'h11;
  localparam logic [4:0] ALU_OP_MINUS_ONE = 5'h12;
  localparam logic [4:0] ALU_OP_ZERO_SIGN_TEST = 5'h13;
  localparam logic [4:0] ALU_OP_IO_BIT_SET = 5'h14;
  localparam logic [4:0] ALU_OP_IO_BIT_CLEAR = 5'h15;
  localparam logic [4:0] ALU_OP_SKIP_IF_IO_BIT_ONE = 5'h16;
  localparam logic [4:0] ALU_OP_SKIP_IF_IO_BIT_ZERO = 5'h17;

  typedef enum logic [1:0] {ALU_IDLE, ALU_EXEC, ALU_EXEC2} alu_state_t;

  // io bits that clear when written with one
  function automatic logic [7:0] alu_w1c_mask(input logic [4:0] addr);
    unique case (addr)
      5'h0e: alu_w1c_mask = 8'he0;
      5'h0b: alu_w1c_mask = 8'h27;
      5'h08: alu_w1c_mask = 8'h10;
      5'h06: alu_w1c_mask = 8'h10;
      default: alu_w1c_mask = 8'h00;
    endcase
  endfunction
endpackage

// ===== verification/alu_core_asserts.sv
// concurrent checks on the datapath ports
`timescale 1ns/1ps
`default_nettype none
module alu_asserts (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // status
  input wire logic BUSY,
  input wire logic SKIP
);
  wire logic acc = PSEL && PENABLE;
  wire logic rd_acc = acc && !PWRITE;
  // only aligned words up to the io data register decode
  wire logic mapped = PADDR[1:0] == 2'h0 && PADDR <= alu_pkg::ALU_IO_DATA_OFFSET;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  AST_READY_CE: assert property (PREADY == CE)
    else $error("ready does not follow enable");
  AST_DECODE: assert property (acc && CE |-> PSLVERR == !mapped)
    else $error("error response does not match decode");
  AST_ERR_ACCESS: assert property (PSLVERR |-> acc)
    else $error("error response outside access phase");
  AST_RDATA_IDLE: assert property (!rd_acc |-> PRDATA == 32'h0)
    else $error("read data not zero outside a read");
  AST_STATUS_BITS: assert property (rd_acc && PADDR == alu_pkg::ALU_STATUS_OFFSET |->
    PRDATA[alu_pkg::ALU_STAT_BUSY] == BUSY && PRDATA[alu_pkg::ALU_STAT_SKIP] == SKIP)
    else $error("status word disagrees with busy or skip");
  AST_BYTE_HIGH: assert property (rd_acc && PADDR == alu_pkg::ALU_GPR_DATA_OFFSET |-> PRDATA[31:8] == 24'h0)
    else $error("register read has upper bits set");
  AST_CMD_START: assert property (acc && PWRITE && CE && !BUSY && PADDR == alu_pkg::ALU_CMD_OFFSET |=> BUSY)
    else $error("command did not start");
  AST_BUSY_BOUND: assert property (BUSY && CE ##1 BUSY && CE |=> !BUSY)
    else $error("operation longer than two clocks");
  AST_FREEZE: assert property (!CE |=> $stable(BUSY) && $stable(SKIP))
    else $error("state moved while enable low");
  AST_SKIP_HOLD: assert property ($changed(SKIP) |-> $past(BUSY))
    else $error("skip result changed without a test");
  COV_WORD: cover property (BUSY && CE ##1 BUSY);
endmodule
bind alu_core alu_asserts u_alu_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY(BUSY), .SKIP(SKIP));
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the arithmetic and logic datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] a_cmd = alu_pkg::ALU_CMD_OFFSET;
  localparam logic [7:0] a_st = alu_pkg::ALU_STATUS_OFFSET;
  localparam logic [7:0] a_gs = alu_pkg::ALU_GPR_SEL_OFFSET;
  localparam logic [7:0] a_gd = alu_pkg::ALU_GPR_DATA_OFFSET;
  localparam logic [7:0] a_is = alu_pkg::ALU_IO_SEL_OFFSET;
  localparam logic [7:0] a_id = alu_pkg::ALU_IO_DATA_OFFSET;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic CE = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic BUSY;
  logic SKIP;
  logic IO_FLAG_STB = 1'b0;
  logic [4:0] IO_FLAG_ADDR = 5'h00;
  logic [7:0] IO_FLAG_SET = 8'h00;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [31:0] busy_n = 32'h0;
  logic [31:0] rd;
  logic err;
  logic [13:0] exp;
  logic [7:0] va [4] = '{8'h7f, 8'h80, 8'h00, 8'h01};
  logic [7:0] vb [4] = '{8'h01, 8'hff, 8'h00, 8'h01};
  logic [7:0] vk [4] = '{8'h80, 8'h0f, 8'h00, 8'h01};
  logic [5:0] vf [4] = '{6'h31, 6'h01, 6'h1e, 6'h3f};
  always #4 SYS_CLK = ~SYS_CLK;
  alu_core uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IO_FLAG_STB(IO_FLAG_STB), .IO_FLAG_ADDR(IO_FLAG_ADDR), .IO_FLAG_SET(IO_FLAG_SET), .BUSY(BUSY), .SKIP(SKIP));
  always @(posedge SYS_CLK) begin
    if (BUSY === 1'b1) begin
      busy_n = busy_n + 32'h1;
    end
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run;
    end
  end
  // byte result in [13:6], flags in [5:0]
  function automatic logic [13:0] model(input logic [4:0] op, input logic [7:0] a, b, k, input logic [5:0] f);
    logic [8:0] r;
    logic [7:0] x, y;
    logic c, h, v, s, lg;
    logic [5:0] m;
    s = !(op inside {5'h00, 5'h01, 5'h11});
    c = (op inside {5'h01, 5'h03, 5'h05}) ? f[0] : 1'b0;
    x = (op == 5'h0e) ? 8'h00 : a;
    y = (op inside {5'h04, 5'h05}) ? k : (op == 5'h0e) ? a : (op inside {5'h11, 5'h12}) ? 8'h01 : b;
    r = s ? {1'b0, x} - {1'b0, y} - c : {1'b0, x} + {1'b0, y} + c;
    h = s ? ({1'b0, x[3:0]} < y[3:0] + c) : (x[3:0] + y[3:0] + c > 5'h0f);
    v = (s ? x[7] != y[7] : x[7] == y[7]) && r[7] != x[7];
    lg = op inside {[5'h08:5'h0d], [5'h0f:5'h10], 5'h13};
    m = lg ? ((op == 5'h0d) ? 6'h0f : 6'h0e) : (op inside {5'h11, 5'h12}) ? 6'h0e : 6'h2f;
    case (op)
      5'h08: r = {1'b0, a & b};
      5'h09: r = {1'b0, a & k};
      5'h0a: r = {1'b0, a | b};
      5'h0b, 5'h0f: r = {1'b0, a | k};
      5'h0c: r = {1'b0, a ^ b};
      5'h0d: r = {1'b1, 8'hff - a};
      5'h10: r = {1'b0, a & (8'hff - k)};
      5'h13: r = {1'b0, a};
      default: ;
    endcase
    v = v && !lg;
    return {r[7:0], ({h, f[4], v, r[7], r[7:0] == 8'h00, r[8]} & m) | (f & ~m)};
  endfunction
  function automatic logic [31:0] cw(input logic [4:0] op, input logic [4:0] d, input logic [5:0] s,
                                     input logic [7:0] k, input logic [2:0] b);
    return {5'h0, b, k, s, d, op};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // hold keeps the bus selected so the next setup follows at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic hold);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    if (!hold) begin
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] want);
    xfer(1'b0, a, 32'h0, 1'b0);
    cmp(rd, want);
  endtask
  task automatic setg(input logic [7:0] r, input logic [7:0] v);
    wr(a_gs, {24'h0, r});
    wr(a_gd, {24'h0, v});
  endtask
  task automatic drain;
    for (n = 0; n < 12 && BUSY !== 1'b0; n++) @(posedge SYS_CLK);
  endtask
  task automatic run(input logic [4:0] op, input logic [5:0] s, input logic [7:0] k, input logic [2:0] b);
    busy_n = 32'h0;
    wr(a_cmd, cw(op, 5'd24, s, k, b));
    drain;
  endtask
  task automatic complete_run;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    chk(a_st, 32'h0);
    for (int t = 0; t < 4; t++) begin
      for (int o = 0; o < 20; o++) begin
        if (o != 6 && o != 7) begin
          setg(8'd7, vb[t]);
          setg(8'd3, va[t]);
          wr(a_st, {26'h0, vf[t]});
          busy_n = 32'h0;
          wr(a_cmd, cw(o[4:0], 5'd3, 6'd7, vk[t], 3'd0));
          drain;
          exp = model(o[4:0], va[t], vb[t], vk[t], vf[t]);
          cmp(busy_n, 32'h1);
          chk(a_gd, {24'h0, exp[13:6]});
          chk(a_st, {26'h0, exp[5:0]});
        end
      end
    end
    setg(8'd25, 8'hff);
    setg(8'd24, 8'hff);
    wr(a_st, 32'h20);
    xfer(1'b1, a_cmd, cw(5'h06, 5'd24, 6'd0, 8'h01, 3'd0), 1'b1);
    CE <= 1'b0;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    cmp({31'h0, BUSY}, 32'h1);
    CE <= 1'b1;
    drain;
    chk(a_gd, 32'h0);
    chk(a_st, 32'h23);
    setg(8'd25, 8'h80);
    setg(8'd24, 8'h00);
    wr(a_st, 32'h20);
    run(5'h07, 6'd0, 8'h41, 3'd0);
    cmp(busy_n, 32'h2);
    chk(a_gd, 32'hff);
    chk(a_st, 32'h38);
    setg(8'd9, 8'h55);
    xfer(1'b1, a_cmd, cw(5'h06, 5'd24, 6'd0, 8'h01, 3'd0), 1'b1);
    xfer(1'b1, a_gd, 32'haa, 1'b0);
    drain;
    chk(a_gd, 32'h55);
    IO_FLAG_ADDR <= 5'h0e;
    IO_FLAG_SET <= 8'he0;
    IO_FLAG_STB <= 1'b1;
    @(posedge SYS_CLK);
    IO_FLAG_STB <= 1'b0;
    wr(a_is, 32'h0e);
    chk(a_id, 32'he0);
    run(5'h14, 6'h0e, 8'h00, 3'd5);
    cmp(busy_n, 32'h2);
    chk(a_id, 32'hc0);
    wr(a_id, 32'h9f);
    chk(a_id, 32'h5f);
    run(5'h15, 6'h0e, 8'h00, 3'd0);
    chk(a_id, 32'h5e);
    run(5'h14, 6'h12, 8'h00, 3'd3);
    run(5'h14, 6'h20, 8'h00, 3'd1);
    run(5'h15, 6'h32, 8'h00, 3'd3);
    wr(a_is, 32'h12);
    chk(a_id, 32'h08);
    wr(a_is, 32'h00);
    chk(a_id, 32'h00);
    run(5'h16, 6'h12, 8'h00, 3'd3);
    cmp({31'h0, SKIP}, 32'h1);
    run(5'h17, 6'h12, 8'h00, 3'd3);
    cmp({31'h0, SKIP}, 32'h0);
    run(5'h17, 6'h12, 8'h00, 3'd2);
    cmp({31'h0, SKIP}, 32'h1);
    run(5'h16, 6'h32, 8'h00, 3'd3);
    cmp({31'h0, SKIP}, 32'h0);
    xfer(1'b0, 8'h18, 32'h0, 1'b0);
    cmp({rd[30:0], err}, 32'h1);
    xfer(1'b1, 8'h1c, 32'h1, 1'b0);
    cmp({31'h0, err}, 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
